// ---- timr_map.vh ----
// Function
// - Two-byte counts need both byte reads; other counters' accesses may fall between.
// - Ports 40h, 41h, 42h are count ports of counters zero, one, two.
// - Simple read gives live count; counter two halts while its gate is low.
// - Latch command on port 43h captures the selected count at that moment.
// - Latched count holds until fully read or reprogrammed, then live again.
// - Latch command leaves mode and count format unchanged.
// - Latch command to an unread latched counter is ignored; first value stays.
// - Read-back captures count and/or status byte of each selected counter.
// - Read-back latches several counters; each releases on its own read.
// - Repeat read-back count latches on an unread count are ignored.
// - Repeat status latches on an unread status are ignored.
// - Latched status is read through the counter's own count port.
// - Count-and-status read-back acts as two consecutive read-backs.
// - Status read first, then one or two count bytes, then live count.
// - Control port takes counter select, mode, format and BCD choice.
// - Count bytes follow format: low only, high only, or low then high.
// - All counters step at one twelfth of the 14.31818 MHz timer clock.
`ifndef TIMR_MAP_VH
`define TIMR_MAP_VH
// ------------------------------------------------------------
// Port map
// ------------------------------------------------------------
`define TIMR_PORT_CNT0 8'h40
`define TIMR_PORT_CNT1 8'h41
`define TIMR_PORT_CNT2 8'h42
`define TIMR_PORT_CMD 8'h43
// ------------------------------------------------------------
// Command word fields
// ------------------------------------------------------------
`define TIMR_CW_SEL_HI 7
`define TIMR_CW_SEL_LO 6
`define TIMR_CW_RW_HI 5
`define TIMR_CW_RW_LO 4
`define TIMR_CW_MODE_HI 3
`define TIMR_CW_MODE_LO 1
`define TIMR_CW_BCD 0
`define TIMR_SEL_RDBK 2'h3
`define TIMR_RW_LATCH 2'h0
`define TIMR_RW_LOW 2'h1
`define TIMR_RW_HIGH 2'h2
`define TIMR_RW_BOTH 2'h3
`define TIMR_RB_NCOUNT 5
`define TIMR_RB_NSTATUS 4
`define TIMR_RB_SEL_LO 1
// ------------------------------------------------------------
// Status byte fields and reset values
// ------------------------------------------------------------
`define TIMR_ST_OUT 7
`define TIMR_ST_NULL 6
`define TIMR_CTL_RST 6'h00
`define TIMR_CNT_RST 16'h0000
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TIMR_REF_HZ 27'd100000000
`define TIMR_TCLK_HZ 27'd14318180
`define TIMR_TCLK_DIV 4'd12
`endif

// ---- timr_core.v ----
`timescale 1ns/1ns
`include "timr_map.vh"
module timr_core (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Control
    input wire tick,
    input wire gate,
    input wire prog,
    input wire load,
    input wire [2:0] mode,
    input wire bcd,
    input wire [15:0] init,
    // State
    output reg [15:0] count_r,
    output reg out_r,
    output reg null_r
);
    reg pend_r;
    wire [15:0] dec;
    wire periodic;
    wire strobe;

    // ------------------------------------------------------------
    // Decrement, binary or per-digit BCD
    // ------------------------------------------------------------
    function [15:0] dec16;
        input [15:0] v;
        input b;
        reg [15:0] r;
        integer k;
        reg brw;
        begin
            r = v - 16'h0001;
            if (b) begin
                brw = 1'b1;
                for (k = 0; k < 4; k = k + 1) begin
                    if (brw) begin
                        if (v[k*4 +: 4] == 4'h0) begin
                            r[k*4 +: 4] = 4'h9;
                        end else begin
                            r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
                            brw = 1'b0;
                        end
                    end else begin
                        r[k*4 +: 4] = v[k*4 +: 4];
                    end
                end
            end
            dec16 = r;
        end
    endfunction

    assign dec = dec16(count_r, bcd);
    assign periodic = mode[1];
    assign strobe = mode[2] & ~mode[1];

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_r <= `TIMR_CNT_RST;
            out_r <= 1'b0;
            null_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (prog) begin
            out_r <= periodic | strobe;
            null_r <= 1'b1;
            pend_r <= 1'b0;
        end else if (load) begin
            null_r <= 1'b1;
            pend_r <= 1'b1;
        end else if (tick) begin
            if (pend_r) begin
                // New count takes effect on the first counter tick after the load pulse
                count_r <= init;
                null_r <= 1'b0;
                pend_r <= 1'b0;
                out_r <= periodic | strobe;
            end else if (gate) begin
                if (periodic && count_r == 16'h0001) begin
                    count_r <= init;
                    out_r <= mode[0] ? ~out_r : 1'b1;
                end else begin
                    count_r <= dec;
                    if (periodic && !mode[0]) begin
                        out_r <= (dec != 16'h0001);
                    end else if (strobe) begin
                        out_r <= (dec != 16'h0000);
                    end else if (!periodic && dec == 16'h0000) begin
                        out_r <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // timr_core

// ---- timr_top.v ----
`timescale 1ns/1ns
`include "timr_map.vh"
module timr_top (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // I/O port bus
    input wire [7:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata_r,
    output reg io_rvalid_r,
    // Speaker gate of counter two
    input wire cnt2_gate,
    // Counter outputs
    output wire [2:0] timer_out
);
    // ------------------------------------------------------------
    // Timer clock enable from the reference clock
    // ------------------------------------------------------------
    reg [26:0] acc_r;
    reg [3:0] div_r;
    reg tick_r;
    wire [26:0] acc_sum;
    wire tclk_en;

    assign acc_sum = acc_r + `TIMR_TCLK_HZ;
    assign tclk_en = (acc_sum >= `TIMR_REF_HZ);

    // Phase accumulator keeps the long-run rate exact at the cost of 10 ns jitter
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_r <= 27'h0000000;
            div_r <= 4'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            acc_r <= tclk_en ? acc_sum - `TIMR_REF_HZ : acc_sum;
            if (tclk_en) begin
                if (div_r == `TIMR_TCLK_DIV - 4'd1) begin
                    div_r <= 4'h0;
                    tick_r <= 1'b1;
                end else begin
                    div_r <= div_r + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [2:0] port_hit;
    wire cmd_hit;
    assign port_hit[0] = (io_addr == `TIMR_PORT_CNT0);
    assign port_hit[1] = (io_addr == `TIMR_PORT_CNT1);
    assign port_hit[2] = (io_addr == `TIMR_PORT_CNT2);
    assign cmd_hit = (io_addr == `TIMR_PORT_CMD);

    wire [1:0] cw_sel;
    wire [1:0] cw_rw;
    wire is_rdbk;
    wire is_latch;
    wire is_ctl;
    assign cw_sel = io_wdata[`TIMR_CW_SEL_HI:`TIMR_CW_SEL_LO];
    assign cw_rw = io_wdata[`TIMR_CW_RW_HI:`TIMR_CW_RW_LO];
    assign is_rdbk = io_wr && cmd_hit && cw_sel == `TIMR_SEL_RDBK;
    assign is_latch = io_wr && cmd_hit && !is_rdbk && cw_rw == `TIMR_RW_LATCH;
    assign is_ctl = io_wr && cmd_hit && !is_rdbk && cw_rw != `TIMR_RW_LATCH;

    // ------------------------------------------------------------
    // Per-counter read-out state
    // ------------------------------------------------------------
    reg [5:0] ctl_r [0:2];
    reg [15:0] init_r [0:2];
    reg [15:0] lat_r [0:2];
    reg [7:0] sts_r [0:2];
    reg [2:0] lat_v_r;
    reg [2:0] sts_v_r;
    reg [2:0] rd_hi_r;
    reg [2:0] wr_hi_r;
    reg [2:0] prog_r;
    reg [2:0] load_r;

    wire [15:0] live [0:2];
    wire [2:0] null_cnt;
    wire [2:0] gate;
    assign gate = {cnt2_gate, 1'b1, 1'b1};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : chan
            timr_core u_core (
                .ref_clk(ref_clk),
                .rst(rst),
                .tick(tick_r),
                .gate(gate[g]),
                .prog(prog_r[g]),
                .load(load_r[g]),
                .mode(ctl_r[g][3:1]),
                .bcd(ctl_r[g][0]),
                .init(init_r[g]),
                .count_r(live[g]),
                .out_r(timer_out[g]),
                .null_r(null_cnt[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Commands, count writes and reads
    // ------------------------------------------------------------
    // ------------------------------------------------------------
    // Read byte and latch release, per counter
    // ------------------------------------------------------------
    integer j;
    reg [15:0] src;
    reg [23:0] rd_byte;
    reg [2:0] rd_last;

    always @* begin
        src = 16'h0000;
        rd_byte = 24'h000000;
        rd_last = 3'h0;
        for (j = 0; j < 3; j = j + 1) begin
            src = lat_v_r[j] ? lat_r[j] : live[j];
            if (sts_v_r[j]) begin
                rd_byte[j*8 +: 8] = sts_r[j];
            end else begin
                case (ctl_r[j][5:4])
                    `TIMR_RW_HIGH: begin
                        rd_byte[j*8 +: 8] = src[15:8];
                        rd_last[j] = 1'b1;
                    end
                    `TIMR_RW_BOTH: begin
                        // Pointer is per counter, so other ports may interleave
                        rd_byte[j*8 +: 8] = rd_hi_r[j] ? src[15:8] : src[7:0];
                        rd_last[j] = rd_hi_r[j];
                    end
                    default: begin
                        rd_byte[j*8 +: 8] = src[7:0];
                        rd_last[j] = 1'b1;
                    end
                endcase
            end
        end
    end

    integer i;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lat_v_r <= 3'h0;
            sts_v_r <= 3'h0;
            rd_hi_r <= 3'h0;
            wr_hi_r <= 3'h0;
            prog_r <= 3'h0;
            load_r <= 3'h0;
            io_rdata_r <= 8'h00;
            io_rvalid_r <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                ctl_r[i] <= `TIMR_CTL_RST;
                init_r[i] <= `TIMR_CNT_RST;
                lat_r[i] <= `TIMR_CNT_RST;
                sts_r[i] <= 8'h00;
            end
        end else begin
            prog_r <= 3'h0;
            load_r <= 3'h0;
            io_rvalid_r <= io_rd;
            if (io_rd && cmd_hit) begin
                io_rdata_r <= 8'h00;
            end
            for (i = 0; i < 3; i = i + 1) begin
                // Control word: reprogramming drops any held values
                if (is_ctl && cw_sel == i[1:0]) begin
                    ctl_r[i] <= io_wdata[5:0];
                    prog_r[i] <= 1'b1;
                    lat_v_r[i] <= 1'b0;
                    sts_v_r[i] <= 1'b0;
                    rd_hi_r[i] <= 1'b0;
                    wr_hi_r[i] <= 1'b0;
                end
                // Latch command touches only the hold register
                if (is_latch && cw_sel == i[1:0] && !lat_v_r[i]) begin
                    lat_r[i] <= live[i];
                    lat_v_r[i] <= 1'b1;
                end
                if (is_rdbk && io_wdata[`TIMR_RB_SEL_LO + i]) begin
                    // Count and status handled independently, as two commands would be
                    if (!io_wdata[`TIMR_RB_NCOUNT] && !lat_v_r[i]) begin
                        lat_r[i] <= live[i];
                        lat_v_r[i] <= 1'b1;
                    end
                    if (!io_wdata[`TIMR_RB_NSTATUS] && !sts_v_r[i]) begin
                        sts_r[i] <= {timer_out[i], null_cnt[i], ctl_r[i]};
                        sts_v_r[i] <= 1'b1;
                    end
                end
                // Count write, per-counter byte pointer
                if (io_wr && port_hit[i]) begin
                    case (ctl_r[i][5:4])
                        `TIMR_RW_LOW: begin
                            init_r[i] <= {8'h00, io_wdata};
                            load_r[i] <= 1'b1;
                        end
                        `TIMR_RW_HIGH: begin
                            init_r[i] <= {io_wdata, 8'h00};
                            load_r[i] <= 1'b1;
                        end
                        `TIMR_RW_BOTH: begin
                            if (!wr_hi_r[i]) begin
                                init_r[i][7:0] <= io_wdata;
                                wr_hi_r[i] <= 1'b1;
                            end else begin
                                init_r[i][15:8] <= io_wdata;
                                wr_hi_r[i] <= 1'b0;
                                load_r[i] <= 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                // Read: status first, then held count, then live count
                if (io_rd && port_hit[i]) begin
                    if (sts_v_r[i]) begin
                        sts_v_r[i] <= 1'b0;
                    end else begin
                        if (ctl_r[i][5:4] == `TIMR_RW_BOTH) begin
                            rd_hi_r[i] <= ~rd_hi_r[i];
                        end
                        if (rd_last[i]) begin
                            lat_v_r[i] <= 1'b0;
                        end
                    end
                    io_rdata_r <= rd_byte[i*8 +: 8];
                end
            end
        end
    end
endmodule // timr_top

// ---- timr_checker.sv ----
`timescale 1ns/1ns
`include "timr_map.vh"
module timr_checker (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // I/O port bus
    input wire [7:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata_r,
    input wire io_rvalid_r,
    // Gate and outputs
    input wire cnt2_gate,
    input wire [2:0] timer_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Status shadow of counter zero
    // ------------------------------------------------------------
    reg [5:0] ctl0_r;
    reg [6:0] st0_r;
    reg st0_v_r;
    wire cmd_wr = io_wr && io_addr == `TIMR_PORT_CMD;
    wire rb0_st = cmd_wr && io_wdata[7:6] == `TIMR_SEL_RDBK && !io_wdata[`TIMR_RB_NSTATUS] && io_wdata[`TIMR_RB_SEL_LO];
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl0_r <= `TIMR_CTL_RST;
            st0_r <= 7'h00;
            st0_v_r <= 1'b0;
        end else if (cmd_wr && io_wdata[7:6] == 2'h0 && io_wdata[5:4] != `TIMR_RW_LATCH) begin
            ctl0_r <= io_wdata[5:0];
            st0_v_r <= 1'b0;
        end else if (rb0_st && !st0_v_r) begin
            // Later status latches leave the first capture alone
            st0_r <= {timer_out[0], ctl0_r};
            st0_v_r <= 1'b1;
        end else if (io_rd && io_addr == `TIMR_PORT_CNT0) begin
            st0_v_r <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_rd_answer;
        io_rd |=> io_rvalid_r;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
    property p_rd_quiet;
        !io_rd |=> !io_rvalid_r;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read valid without a read");
    property p_rdata_hold;
        !io_rd |=> $stable(io_rdata_r);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
    property p_unmapped;
        io_rd && (io_addr < `TIMR_PORT_CNT0 || io_addr > `TIMR_PORT_CMD) |=> $stable(io_rdata_r);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read changed data");
    property p_cmd_rd;
        io_rd && io_addr == `TIMR_PORT_CMD |=> io_rdata_r == 8'h00;
    endproperty
    a_cmd_rd: assert property (p_cmd_rd) else $error("command port read not zero");
    property p_st_ctl;
        io_rd && io_addr == `TIMR_PORT_CNT0 && st0_v_r |=> io_rdata_r[5:0] == st0_r[5:0];
    endproperty
    a_st_ctl: assert property (p_st_ctl) else $error("status control field wrong");
    property p_st_out;
        io_rd && io_addr == `TIMR_PORT_CNT0 && st0_v_r |=> io_rdata_r[`TIMR_ST_OUT] == st0_r[6];
    endproperty
    a_st_out: assert property (p_st_out) else $error("status output level wrong");
    property p_rst_idle;
        $fell(rst) |-> !io_rvalid_r && timer_out == 3'h0;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
endmodule // timr_checker

bind timr_top timr_checker u_timr_checker (
    .ref_clk(ref_clk),
    .rst(rst),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata_r(io_rdata_r),
    .io_rvalid_r(io_rvalid_r),
    .cnt2_gate(cnt2_gate),
    .timer_out(timer_out)
);

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "timr_map.vh"
module testbench;
    localparam [7:0] port_c0 = `TIMR_PORT_CNT0;
    localparam [7:0] port_c1 = `TIMR_PORT_CNT1;
    localparam [7:0] port_c2 = `TIMR_PORT_CNT2;
    localparam [7:0] port_cmd = `TIMR_PORT_CMD;
    reg ref_clk;
    reg rst;
    reg [7:0] io_addr;
    reg io_wr;
    reg io_rd;
    reg [7:0] io_wdata;
    reg cnt2_gate;
    wire [7:0] io_rdata_r;
    wire io_rvalid_r;
    wire [2:0] timer_out;
    integer err_total;
    integer checked;
    reg [31:0] seed_r;
    reg [7:0] rd_v;
    reg [15:0] cnt_a;
    reg [15:0] cnt_b;
    timr_top u_timr_top (
        .ref_clk(ref_clk),
        .rst(rst),
        .io_addr(io_addr),
        .io_wr(io_wr),
        .io_rd(io_rd),
        .io_wdata(io_wdata),
        .io_rdata_r(io_rdata_r),
        .io_rvalid_r(io_rvalid_r),
        .cnt2_gate(cnt2_gate),
        .timer_out(timer_out)
    );
    always #5 ref_clk = ~ref_clk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [31:0] f_xorshift(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            f_xorshift = y ^ (y << 5);
        end
    endfunction
    function [7:0] f_status(input out_lvl, input null_flag, input [7:0] cw);
        f_status = {out_lvl, null_flag, cw[5:0]};
    endfunction
    // About 84 ref cycles per count step, so ~830 cycles give 8..12 steps
    function f_span(input [15:0] older, input [15:0] newer);
        f_span = (older - newer >= 16'd8) && (older - newer <= 16'd12);
    endfunction
    task chk8(input [7:0] exp, input [7:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
            end
        end
    endtask
    task chk1(input exp, input got);
        chk8({7'h00, exp}, {7'h00, got});
    endtask
    // Strobes start on a fresh falling edge so no signal is set twice at once
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge ref_clk);
            io_addr = a;
            io_wdata = d;
            io_wr = 1'b1;
            @(negedge ref_clk);
            io_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(negedge ref_clk);
            io_addr = a;
            io_rd = 1'b1;
            @(negedge ref_clk);
            io_rd = 1'b0;
            rd_v = io_rdata_r;
            chk1(1'b1, io_rvalid_r);
        end
    endtask
    task rd16(input [7:0] a, output [15:0] v);
        begin
            rd(a);
            v[7:0] = rd_v;
            rd(a);
            v[15:8] = rd_v;
        end
    endtask
    task latch_run(input [7:0] c_a, input [7:0] c_b, input [7:0] c_c);
        begin
            wr(port_cmd, c_a);
            wr(port_cmd, c_b);
            repeat (400) @(negedge ref_clk);
            wr(port_cmd, c_a);
            wr(port_cmd, c_c);
            repeat (400) @(negedge ref_clk);
        end
    endtask
    task latched_reads;
        reg [15:0] v1;
        reg [15:0] v2;
        reg [7:0] c1;
        begin
            rd(port_c0);
            v1[7:0] = rd_v;
            rd(port_c1);
            c1 = rd_v;
            rd(port_c0);
            v1[15:8] = rd_v;
            rd16(port_c0, v2);
            rd(port_c1);
            chk1(1'b1, f_span(v1, v2));
            chk1(1'b1, f_span({8'h00, c1}, {8'h00, rd_v}));
        end
    endtask
    task stop_test;
        begin
            $display("Comparisons %0d, mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #1000000;
        err_total = err_total + 1;
        stop_test;
    end
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        io_addr = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        cnt2_gate = 1'b0;
        err_total = 0;
        checked = 0;
        seed_r = 32'd62;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        rd(port_cmd);
        chk8(8'h00, rd_v);
        seed_r = f_xorshift(seed_r);
        cnt_a = {1'b1, seed_r[14:0]};
        wr(port_cmd, 8'h34);
        wr(port_c0, cnt_a[7:0]);
        wr(port_c0, cnt_a[15:8]);
        seed_r = f_xorshift(seed_r);
        wr(port_cmd, 8'h50);
        wr(port_c1, {2'h3, seed_r[5:0]});
        repeat (200) @(negedge ref_clk);
        // Latch commands on two counters, repeats ignored
        latch_run(8'h00, 8'h40, 8'h40);
        latched_reads;
        // Read-back: count before status on counter one, both at once on zero
        latch_run(8'hD4, 8'hC2, 8'hC6);
        rd(port_c0);
        chk8(f_status(1'b1, 1'b0, 8'h34), rd_v);
        rd(port_c1);
        chk8(f_status(1'b0, 1'b0, 8'h50), rd_v);
        latched_reads;
        cnt_b = {8'h00, rd_v};
        rd(8'h3F);
        chk8(cnt_b[7:0], rd_v);
        // Fresh control word shows null count; BCD low-only and high-only reads
        wr(port_cmd, 8'h15);
        wr(port_cmd, 8'hE2);
        rd(port_c0);
        chk8(f_status(1'b1, 1'b1, 8'h15), rd_v);
        wr(port_c0, 8'h10);
        repeat (200) @(negedge ref_clk);
        rd(port_c0);
        chk1(1'b1, rd_v == 8'h08 || rd_v == 8'h09);
        wr(port_cmd, 8'h25);
        wr(port_c0, 8'h12);
        repeat (200) @(negedge ref_clk);
        rd(port_c0);
        chk8(8'h11, rd_v);
        // Counter two holds still while its gate is low
        seed_r = f_xorshift(seed_r);
        wr(port_cmd, 8'hB0);
        wr(port_c2, seed_r[7:0]);
        wr(port_c2, {1'b1, seed_r[14:8]});
        repeat (200) @(negedge ref_clk);
        rd16(port_c2, cnt_a);
        repeat (400) @(negedge ref_clk);
        rd16(port_c2, cnt_b);
        chk1(1'b1, cnt_a === cnt_b);
        cnt2_gate = 1'b1;
        repeat (400) @(negedge ref_clk);
        rd16(port_c2, cnt_b);
        chk1(1'b1, cnt_a !== cnt_b);
        stop_test;
    end
endmodule // testbench
